// ---- qdsw_defines.vh ----
// Constants for the serial write port of the four-channel converter.
// Assumes inclusion by every design file that needs widths or stage counts.
`ifndef QDSW_DEFINES_VH
`define QDSW_DEFINES_VH
`define QDSW_WORD_W 24
`define QDSW_CNT_W 5
`define QDSW_LAST_BIT 5'h17
`define QDSW_CNT_ONE 5'h01
`define QDSW_PIN_N 4'h7
`define QDSW_PIN_RST 7'h09
`define QDSW_PIN_SYNC 3'h0
`define QDSW_PIN_SCLK 3'h1
`define QDSW_PIN_DATA 3'h2
`define QDSW_PIN_EN 3'h3
`define QDSW_PIN_A0 3'h4
`define QDSW_PIN_A1 3'h5
`define QDSW_PIN_LD 3'h6
`define QDSW_SYNC_W 3
`define QDSW_ADDR_W 2
`define QDSW_PEND_RST 24'h000000
`define QDSW_ST_IDLE 2'h0
`define QDSW_ST_SHIFT 2'h1
`define QDSW_ST_DONE 2'h2
`endif

// ---- qdsw_host_model.sv ----
// Host serial master model.
// Calls start just after a core clock edge; serial clock period 80 ns.
`timescale 1ns/1ns
module qdsw_host_model (
   output reg frameSync_b,
   output reg serialClk,
   output reg serialData
);
   initial begin
      frameSync_b = 1'h1;
      serialClk = 1'h1;
      serialData = 1'h0;
   end
   // Sends n bits MSB first, repeating past 24; fewer than 24 aborts.
   task send(input [23:0] w, input integer n);
      integer k;
      begin
         frameSync_b = 1'h0;
         for (k = 0; k < n; k = k + 1) begin
            serialData = w[23 - k % 24];
            #40 serialClk = 1'h0;
            #40 serialClk = 1'h1;
         end
         #20 frameSync_b = 1'h1;
         serialData = ~serialData;
         #80;
      end
   endtask
endmodule // qdsw_host_model

// ---- qdsw_monitor.sv ----
// Checker on the write port outputs.
// Bound to every write port instance.
`timescale 1ns/1ns
module qdsw_monitor (
   input core_clk,
   input rst_b,
   input frameSync_b,
   input portEnable_b,
   input addr_select_0,
   input addr_select_1,
   input load_all_strobe,
   input [23:0] wordOut,
   input wordValid,
   input [23:0] channelLoadWord,
   input channelLoad,
   input frameAbort,
   input [1:0] deviceAddr
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   property p_v; wordValid |=> !wordValid; endproperty
   a_v: assert property (p_v) else $error("long valid");
   property p_f; frameAbort |-> !wordValid; endproperty
   a_f: assert property (p_f) else $error("abort valid");
   property p_w; $changed(wordOut) |-> wordValid; endproperty
   a_w: assert property (p_w) else $error("word moved");
   property p_s; wordValid |-> !$past(frameSync_b, 5); endproperty
   a_s: assert property (p_s) else $error("no frame");
   property p_e; portEnable_b [*8] |-> !wordValid; endproperty
   a_e: assert property (p_e) else $error("port off");
   property p_l; $rose(load_all_strobe) |-> ##[3:6] channelLoad; endproperty
   a_l: assert property (p_l) else $error("no load");
   property p_c; $changed(channelLoadWord) |-> channelLoad; endproperty
   a_c: assert property (p_c) else $error("load moved");
   property p_a; deviceAddr != {addr_select_1, addr_select_0} |-> ##[1:8]
      deviceAddr == {addr_select_1, addr_select_0}; endproperty
   a_a: assert property (p_a) else $error("bad addr");
endmodule // qdsw_monitor
bind qdsw_write_port qdsw_monitor i_qdsw_monitor (.core_clk, .rst_b, .frameSync_b,
   .portEnable_b, .addr_select_0, .addr_select_1, .load_all_strobe, .wordOut,
   .wordValid, .channelLoadWord, .channelLoad, .frameAbort, .deviceAddr);

// ---- qdsw_pin_sync.v ----
// Three-stage synchroniser with agreement filter for one asynchronous pin.
// Assumes the pin is free-running relative to core_clk; output is a clean level.
`timescale 1ns/1ns
`include "qdsw_defines.vh"
module qdsw_pin_sync #(
   parameter RESET_LEVEL = 1'b0
) (
   input wire core_clk,
   input wire rst_b,
   input wire pinIn,
   output reg levelOut
);
   reg stage1_reg;
   reg stage2_reg;
   reg stage3_reg;

   // The filtered level changes only once the second and third stages agree.
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         stage1_reg <= RESET_LEVEL;
         stage2_reg <= RESET_LEVEL;
         stage3_reg <= RESET_LEVEL;
         levelOut <= RESET_LEVEL;
      end else begin
         stage1_reg <= pinIn;
         stage2_reg <= stage1_reg;
         stage3_reg <= stage2_reg;
         if (stage2_reg == stage3_reg) begin
            levelOut <= stage3_reg;
         end
      end
   end
endmodule // qdsw_pin_sync

// ---- qdsw_write_port.v ----
// Serial write front end: frame sync, serial clock and data into a 24-bit word.
// Assumes all pins are asynchronous to core_clk and the serial clock is much slower.
// Assumes the host keeps its own pin timing; none of it is checked here.
// Assumes downstream command logic decodes the word and routes it to a channel.
// Assumes each serial clock level lasts several core clocks so the filter sees it.
`timescale 1ns/1ns
`include "qdsw_defines.vh"
module qdsw_write_port (
   input wire core_clk,
   input wire rst_b,
   input wire frameSync_b,
   input wire serialClk,
   input wire serialData,
   input wire portEnable_b,
   input wire addr_select_0,
   input wire addr_select_1,
   input wire load_all_strobe,
   output reg [`QDSW_WORD_W-1:0] wordOut,
   output reg wordValid,
   output reg [`QDSW_WORD_W-1:0] channelLoadWord,
   output reg channelLoad,
   output reg frameAbort,
   output reg [`QDSW_ADDR_W-1:0] deviceAddr
);
   wire syncLevel;
   wire sclkLevel;
   wire dataLevel;
   wire enLevel;
   wire addr0Level;
   wire addr1Level;
   wire ldLevel;
   wire [`QDSW_PIN_N-1:0] pinRaw;
   wire [`QDSW_PIN_N-1:0] pinLevel;
   // Frame sync and port enable rest high, so their synchronisers start high.
   localparam [`QDSW_PIN_N-1:0] PIN_RST = `QDSW_PIN_RST;
   genvar pinIdx;

   assign pinRaw[`QDSW_PIN_SYNC] = frameSync_b;
   assign pinRaw[`QDSW_PIN_SCLK] = serialClk;
   assign pinRaw[`QDSW_PIN_DATA] = serialData;
   assign pinRaw[`QDSW_PIN_EN] = portEnable_b;
   assign pinRaw[`QDSW_PIN_A0] = addr_select_0;
   assign pinRaw[`QDSW_PIN_A1] = addr_select_1;
   assign pinRaw[`QDSW_PIN_LD] = load_all_strobe;

   // Every pin is asynchronous to core_clk, so each has its own filtered synchroniser.
   generate
      for (pinIdx = 0; pinIdx < `QDSW_PIN_N; pinIdx = pinIdx + 1) begin : g_pin
         qdsw_pin_sync #(
            .RESET_LEVEL(PIN_RST[pinIdx])
         ) i_qdsw_pin_sync (
            .core_clk(core_clk),
            .rst_b(rst_b),
            .pinIn(pinRaw[pinIdx]),
            .levelOut(pinLevel[pinIdx])
         );
      end
   endgenerate

   assign syncLevel = pinLevel[`QDSW_PIN_SYNC];
   assign sclkLevel = pinLevel[`QDSW_PIN_SCLK];
   assign dataLevel = pinLevel[`QDSW_PIN_DATA];
   assign enLevel = pinLevel[`QDSW_PIN_EN];
   assign addr0Level = pinLevel[`QDSW_PIN_A0];
   assign addr1Level = pinLevel[`QDSW_PIN_A1];
   assign ldLevel = pinLevel[`QDSW_PIN_LD];

   // Edge history, frame control state and the values they take next.
   reg sclkPrev_reg;
   reg syncPrev_reg;
   reg ldPrev_reg;
   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg [`QDSW_WORD_W-1:0] shift_reg;
   reg [`QDSW_WORD_W-1:0] shift_next;
   reg [`QDSW_CNT_W-1:0] count_reg;
   reg [`QDSW_CNT_W-1:0] count_next;
   reg [`QDSW_WORD_W-1:0] pending_reg;
   reg [`QDSW_WORD_W-1:0] pending_next;
   reg wordDone;
   reg abortNow;

   // Edge detectors compare each filtered level with its copy from one core clock earlier, so they fire in the cycle the level changes.
   wire sclkFall = sclkPrev_reg & ~sclkLevel;
   wire syncFall = syncPrev_reg & ~syncLevel;
   wire syncRise = ~syncPrev_reg & syncLevel;
   wire ldRise = ~ldPrev_reg & ldLevel;
   // Frame sync counts only while the port is connected.
   wire portOn = ~enLevel;

   // Frame control: idle until frame sync falls with the port connected, then one bit
   // per serial clock fall; the last bit completes the word, and the block then waits
   // for frame sync to rise before it can arm again.
   always @* begin
      state_next = state_reg;
      shift_next = shift_reg;
      count_next = count_reg;
      pending_next = pending_reg;
      wordDone = 1'b0;
      abortNow = 1'b0;
      case (state_reg)
         `QDSW_ST_IDLE: begin
            // A frame sync fall while the port is off is dropped, not remembered.
            if (syncFall && portOn) begin
               state_next = `QDSW_ST_SHIFT;
               count_next = {`QDSW_CNT_W{1'b0}};
            end
         end
         `QDSW_ST_SHIFT: begin
            // Frame sync or port enable rising before the last bit drops the frame.
            if (syncLevel || !portOn) begin
               state_next = `QDSW_ST_IDLE;
               abortNow = 1'b1;
            end else if (sclkFall) begin
               // The word arrives most significant bit first.
               shift_next = {shift_reg[`QDSW_WORD_W-2:0], dataLevel};
               if (count_reg == `QDSW_LAST_BIT) begin
                  state_next = `QDSW_ST_DONE;
                  wordDone = 1'b1;
                  pending_next = {shift_reg[`QDSW_WORD_W-2:0], dataLevel};
               end else begin
                  count_next = count_reg + `QDSW_CNT_ONE;
               end
            end
         end
         `QDSW_ST_DONE: begin
            // Extra serial clocks are ignored until frame sync rises.
            if (syncRise || !portOn) begin
               state_next = `QDSW_ST_IDLE;
            end
         end
         default: begin
            state_next = `QDSW_ST_IDLE;
         end
      endcase
   end

   // Edge history of the filtered pins.
   // Reset values equal the synchroniser reset levels, so no false edge follows reset.
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         sclkPrev_reg <= 1'b0;
         syncPrev_reg <= 1'b1;
         ldPrev_reg <= 1'b0;
      end else begin
         sclkPrev_reg <= sclkLevel;
         syncPrev_reg <= syncLevel;
         ldPrev_reg <= ldLevel;
      end
   end

   // Frame state, shifter, bit counter and the word waiting for the load strobe.
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= `QDSW_ST_IDLE;
         shift_reg <= `QDSW_PEND_RST;
         count_reg <= {`QDSW_CNT_W{1'b0}};
         pending_reg <= `QDSW_PEND_RST;
      end else begin
         state_reg <= state_next;
         shift_reg <= shift_next;
         count_reg <= count_next;
         pending_reg <= pending_next;
      end
   end

   // Received-word outputs; the word register holds until the next complete frame.
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         wordOut <= `QDSW_PEND_RST;
         wordValid <= 1'b0;
         frameAbort <= 1'b0;
      end else begin
         wordValid <= wordDone;
         frameAbort <= abortNow;
         if (wordDone) begin
            wordOut <= pending_next;
         end
      end
   end

   // Load outputs; a strobe with no new word reloads the word already pending.
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         channelLoadWord <= `QDSW_PEND_RST;
         channelLoad <= 1'b0;
      end else begin
         channelLoad <= ldRise;
         if (ldRise) begin
            channelLoadWord <= pending_reg;
         end
      end
   end

   // Device address follows the filtered address-select pins.
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         deviceAddr <= {`QDSW_ADDR_W{1'b0}};
      end else begin
         deviceAddr <= {addr1Level, addr0Level};
      end
   end
endmodule // qdsw_write_port

// ---- quad_dac_serial_write_port_bench.sv ----
// Bench for the write port; host model on the serial pins.
`timescale 1ns/1ns
module quad_dac_serial_write_port_bench;
   reg core_clk = 1'h0, rst_b = 1'h0, portEnable_b = 1'h1, load_all_strobe = 1'h0;
   reg addr_select_0 = 1'h0, addr_select_1 = 1'h0;
   wire frameSync_b, serialClk, serialData, wordValid, channelLoad, frameAbort;
   wire [23:0] wordOut, channelLoadWord;
   wire [1:0] deviceAddr;
   integer mismatches = 0, checked = 0, nV = 0, nA = 0, nL = 0, a;
   initial forever #2 core_clk = ~core_clk;
   always @(posedge core_clk) if (wordValid === 1'h1) nV <= nV + 1;
   always @(posedge core_clk) if (frameAbort === 1'h1) nA <= nA + 1;
   always @(posedge core_clk) if (channelLoad === 1'h1) nL <= nL + 1;
   qdsw_write_port i_qdsw_write_port (.core_clk, .rst_b, .frameSync_b, .serialClk,
      .serialData, .portEnable_b, .addr_select_0, .addr_select_1, .load_all_strobe,
      .wordOut, .wordValid, .channelLoadWord, .channelLoad, .frameAbort, .deviceAddr);
   qdsw_host_model i_qdsw_host_model (.frameSync_b, .serialClk, .serialData);
   task check(input [23:0] seen, input [23:0] exp);
      begin
         checked = checked + 1;
         if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
         end
      end
   endtask
   task give_verdict;
      begin
         $display("checked %0d mismatches %0d", checked, mismatches);
         if (mismatches == 0 && checked > 0) $display("Simulation passed");
         else $display("Simulation failed");
         $finish;
      end
   endtask
   task tick(input integer n);
      begin
         repeat (n) @(posedge core_clk);
         #1;
      end
   endtask
   task s_write;
      begin
         portEnable_b = 1'h0;
         tick(4);
         i_qdsw_host_model.send(24'hA5C33C, 26);
         check(wordOut, 24'hA5C33C);
         check(nV[23:0], 24'h1);
         load_all_strobe = 1'h1;
         tick(8);
         check(channelLoadWord, 24'hA5C33C);
         check(nL[23:0], 24'h1);
         check(nA[23:0], 24'h0);
         load_all_strobe = 1'h0;
      end
   endtask
   task s_abort;
      begin
         i_qdsw_host_model.send(24'h5A0FF0, 23);
         check(wordOut, 24'hA5C33C);
         check(nA[23:0], 24'h1);
         portEnable_b = 1'h1;
         tick(4);
         i_qdsw_host_model.send(24'h123456, 24);
         check(nV[23:0], 24'h1);
         check(nA[23:0], 24'h1);
      end
   endtask
   task s_addr;
      for (a = 3; a >= 0; a = a - 1) begin
         {addr_select_1, addr_select_0} = a[1:0];
         tick(8);
         check({22'h0, deviceAddr}, {22'h0, a[1:0]});
      end
   endtask
   initial begin
      tick(20);
      rst_b = 1'h1;
      tick(8);
      s_addr;
      s_write;
      s_abort;
      give_verdict;
   end
   initial begin
      #100000;
      mismatches = mismatches + 1;
      give_verdict;
   end
endmodule // quad_dac_serial_write_port_bench
